// *** logic/twsc_channel.sv ***
// twsc_channel: three-wire serial channel, plain mode and stop mode.
// assumes the cpu port is on ref_clk and the pins are external.
`timescale 1ns/1ps
`default_nettype none
module twsc_channel (
    input  wire logic                    ref_clk,      // 250 MHz
    input  wire logic                    rst,          // sync, active high
    input  wire twsc_pkg::twsc_cpu_req_t cpu_req,      // cpu access
    output logic [7:0]                   cpu_rdata,    // read answer
    input  wire logic                    tm2_tick,     // timer 2 output
    input  wire logic                    timer_clock_select_three_tick,    // prescaled clock
    input  wire logic                    receive_enable_bit, // rx enable
    input  wire logic                    sck_pin_in,   // clock pin level
    output logic                         sck_pin_out,  // clock pin drive
    output logic                         sck_pin_oe,   // clock pin enable
    input  wire logic                    si_pin_in,    // serial in pin
    output logic                         so_pin_out,   // serial out pin
    output logic                         so_pin_oe,    // serial out enable
    output twsc_pkg::twsc_pin_own_t      pin_own,      // pin ownership
    output logic                         transfer_done_flag // done pulse
);
    import twsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // mirror a byte end to end
    function automatic logic [7:0] rev8(input logic [7:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7 - i];
        end
        return r;
    endfunction

    // replace one bit of a byte
    function automatic logic [7:0] set_bit(input logic [7:0] d,
                                           input logic [2:0] s,
                                           input logic       v);
        logic [7:0] r;
        r    = d;
        r[s] = v;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0]  mode_reg;      // mode control register
    logic [7:0]  shift_reg;     // shift register, msb leaves first
    twsc_state_t state_reg;     // engine state
    logic [2:0]  bit_cnt_reg;   // serial clock bit counter
    logic        sck_reg;       // internal serial clock level
    logic        so_int_reg;    // output latch for internal clock
    logic        arm_tog_reg;   // toggles to arm the link shifter
    logic        ack_s1_reg;    // link ack, first stage
    logic        ack_s2_reg;    // link ack, second stage
    logic        ack_seen_reg;  // last ack taken
    logic        sck_s1_reg;    // clock pin, first stage
    logic        sck_s2_reg;    // clock pin, second stage
    logic        si_s1_reg;     // serial in, first stage
    logic        si_s2_reg;     // serial in, second stage
    logic        done_reg;      // one-cycle done pulse
    logic [7:0]  rdata_reg;     // read data
    logic        so_ext;        // link output level
    logic        ack_tog;       // link ack toggle
    logic [7:0]  rx_word;       // link received unit

    logic        en;            // channel enable
    logic        lsb_first;     // order select
    logic        auto_sel;      // auto transfer mode
    logic        clk_int;       // internal clock chosen
    logic        tick;          // selected internal clock step
    logic        any_wr;        // byte or bit write
    logic [7:0]  shift_view;    // cpu view of the shift register
    logic [7:0]  mode_wbyte;    // byte written to mode register
    logic [7:0]  shift_wbyte;   // byte written to shift register
    logic        mode_wr;       // write hits mode register
    logic        shift_wr;      // write hits shift register
    logic        start;         // a unit begins this cycle
    logic        ext_done;      // link finished a unit

    assign en        = mode_reg[TWSC_EN_BIT];
    assign lsb_first = mode_reg[TWSC_DIR_BIT];
    assign auto_sel  = mode_reg[TWSC_AUTO_BIT];
    assign clk_int   = mode_reg[TWSC_CLKHI_BIT];
    // prescaler path when low bit set, timer 2 output otherwise
    assign tick      = mode_reg[TWSC_CLKLO_BIT] ? timer_clock_select_three_tick
                                                : tm2_tick;

    ////////////////////////////////////////////////////////////////////////
    // cpu write decode
    assign any_wr     = cpu_req.wr | cpu_req.bit_wr;
    assign mode_wr    = any_wr && (cpu_req.addr == TWSC_MODE_ADDR);
    assign shift_wr   = any_wr && (cpu_req.addr == TWSC_SHIFT_ADDR);
    // order reversal lives only on the cpu side of the register
    assign shift_view = lsb_first ? rev8(shift_reg) : shift_reg;
    // single-bit writes merge into the current view
    assign mode_wbyte = cpu_req.bit_wr
                      ? set_bit(mode_reg, cpu_req.bit_sel, cpu_req.bit_val)
                      : cpu_req.wdata;
    assign shift_wbyte = cpu_req.bit_wr
                      ? set_bit(shift_view, cpu_req.bit_sel,
                                cpu_req.bit_val)
                      : cpu_req.wdata;

    // a unit starts only on the write itself, never on a later enable;
    // external clock must stand high, internal clock must be stopped
    assign start = shift_wr && en && !auto_sel
                && (state_reg == TWSC_IDLE)
                && (clk_int || sck_s2_reg);

    assign ext_done = (ack_s2_reg != ack_seen_reg);

    ////////////////////////////////////////////////////////////////////////
    // mode control register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_reg <= TWSC_MODE_RST;
        end else if (mode_wr) begin
            mode_reg <= mode_wbyte & TWSC_MODE_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stages feed only second stages
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sck_s1_reg <= 1'b1;
            sck_s2_reg <= 1'b1;
            si_s1_reg  <= 1'b0;
            si_s2_reg  <= 1'b0;
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            sck_s1_reg <= sck_pin_in;
            sck_s2_reg <= sck_s1_reg;
            si_s1_reg  <= si_pin_in;
            si_s2_reg  <= si_s1_reg;
            ack_s1_reg <= ack_tog;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    // ack taken every cycle so a stale toggle never fires later
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_seen_reg <= 1'b0;
        end else begin
            ack_seen_reg <= ack_s2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // engine: state, bit counter and internal clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg   <= TWSC_IDLE;
            bit_cnt_reg <= 3'h0;
            sck_reg     <= 1'b1;
        end else if (!en) begin
            // stopped: counter held clear, clock parked high
            state_reg   <= TWSC_IDLE;
            bit_cnt_reg <= 3'h0;
            sck_reg     <= 1'b1;
        end else begin
            case (state_reg)
                TWSC_IDLE: begin
                    sck_reg     <= 1'b1;
                    bit_cnt_reg <= 3'h0;
                    if (start) begin
                        state_reg <= clk_int ? TWSC_INT_RUN
                                             : TWSC_EXT_RUN;
                    end
                end
                TWSC_INT_RUN: begin
                    if (tick) begin
                        sck_reg <= ~sck_reg;
                        if (!sck_reg) begin
                            // rising edge closes one bit
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == TWSC_LAST_BIT) begin
                                state_reg <= TWSC_IDLE;
                            end
                        end
                    end
                end
                TWSC_EXT_RUN: begin
                    if (ext_done) begin
                        state_reg <= TWSC_IDLE;
                    end
                end
                default: begin
                    state_reg <= TWSC_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shift register: cpu storage when idle, shifter when running
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shift_reg <= TWSC_SHIFT_RST;
        end else if (shift_wr && (state_reg == TWSC_IDLE)) begin
            // plain storage when disabled, transmit data when enabled
            shift_reg <= lsb_first ? rev8(shift_wbyte)
                                   : shift_wbyte;
        end else if (en && (state_reg == TWSC_INT_RUN) && tick
                     && !sck_reg) begin
            shift_reg <= {shift_reg[6:0],
                          receive_enable_bit & si_s2_reg};
        end else if (en && (state_reg == TWSC_EXT_RUN) && ext_done) begin
            shift_reg <= rx_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output latch for the internal clock path
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            so_int_reg <= 1'b0;
        end else if (start) begin
            so_int_reg <= 1'b0;
        end else if ((state_reg == TWSC_INT_RUN) && tick && sck_reg) begin
            so_int_reg <= shift_reg[7];
        end
    end

    // arming toggle for the link shifter; held while a unit runs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            arm_tog_reg <= 1'b0;
        end else if (start && !clk_int) begin
            arm_tog_reg <= ~arm_tog_reg;
        end
    end

    // done pulse towards the interrupt request flag
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= en && (((state_reg == TWSC_INT_RUN) && tick
                        && !sck_reg && (bit_cnt_reg == TWSC_LAST_BIT))
                        || ((state_reg == TWSC_EXT_RUN) && ext_done));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cpu read: one cycle after the strobe, unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (cpu_req.rd) begin
            case (cpu_req.addr)
                TWSC_MODE_ADDR:  rdata_reg <= mode_reg;
                TWSC_SHIFT_ADDR: rdata_reg <= shift_view;
                default:         rdata_reg <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link-side shifter for the external clock
    twsc_link_shifter u_link (
        .link_clk (sck_pin_in),
        .rst      (rst),
        .arm_tog  (arm_tog_reg),
        .tx_word  (shift_reg),
        .rx_en    (receive_enable_bit),
        .si       (si_pin_in),
        .so_ext   (so_ext),
        .ack_tog  (ack_tog),
        .rx_word  (rx_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // pins; stopped channel drives nothing so the port owns them
    assign so_pin_oe   = en;
    assign so_pin_out  = !en ? 1'b0 : (clk_int ? so_int_reg : so_ext);
    assign sck_pin_oe  = en && clk_int;
    assign sck_pin_out = sck_reg;
    // one driver for the carrier; strobe and busy are free here
    assign pin_own = '{so_oe:    so_pin_oe,
                       sck_oe:   sck_pin_oe,
                       si_used:  en && receive_enable_bit,
                       released: !en};
    assign cpu_rdata          = rdata_reg;
    assign transfer_done_flag = done_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_mode_after_reset: assert property (
        @(posedge ref_clk) disable iff (1'b0)
        rst |=> (mode_reg == 8'h00))
        else $error("mode register not cleared by reset");

    a_stop_releases: assert property (
        !en |-> (!so_pin_oe && !sck_pin_oe && pin_own.released))
        else $error("stopped channel still drives pins");

    a_stop_no_shift: assert property (
        (!en && !shift_wr) |=> $stable(shift_reg))
        else $error("shift register moved while stopped");

    a_stop_cnt_clear: assert property ($fell(en) |=>
        (bit_cnt_reg == 3'h0 && state_reg == TWSC_IDLE))
        else $error("bit counter not cleared when stopped");

    a_clk_direction: assert property ((en && clk_int) |->
        sck_pin_oe ##0 so_pin_oe)
        else $error("internal clock not driven out");

    a_write_low: assert property ((start && clk_int) |=>
        (so_pin_out == 1'b0))
        else $error("output not low after shift write");

    a_start_cond: assert property ((start && clk_int) |=>
        (state_reg == TWSC_INT_RUN))
        else $error("write did not start a unit");

    a_late_enable: assert property (
        ($rose(en) && !shift_wr) |=> (state_reg == TWSC_IDLE))
        else $error("enable alone started a unit");

    a_idle_high: assert property ((state_reg == TWSC_IDLE) |=>
        sck_reg)
        else $error("internal clock not parked high");

    a_eight_bits: assert property (($rose(done_reg) && clk_int)
        |-> ($past(bit_cnt_reg) == 3'h7))
        else $error("unit ended before eighth bit");

    a_done_pulse: assert property (done_reg |=> !done_reg)
        else $error("done flag not a single pulse");

    a_rx_gate: assert property (!receive_enable_bit |->
        !pin_own.si_used)
        else $error("serial input used with receive off");

    c_int_unit: cover property (start && clk_int ##[1:600] done_reg);
    c_ext_unit: cover property (start && !clk_int ##[1:400] done_reg);
    c_lsb_write: cover property (shift_wr && lsb_first && en);

endmodule : twsc_channel
`default_nettype wire

// *** logic/twsc_pkg.sv ***
// twsc_pkg: constants and carrier types of the three-wire serial channel.
// assumes a cpu-side port on ref_clk and a serial clock pin from outside.
package twsc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map (cpu byte addresses)
    localparam logic [15:0] TWSC_MODE_ADDR  = 16'hFF68; // mode control
    localparam logic [15:0] TWSC_SHIFT_ADDR = 16'hFF69; // shift register

    // mode control register fields
    localparam int          TWSC_EN_BIT     = 7;        // channel enable
    localparam int          TWSC_DIR_BIT    = 6;        // 1 = lsb first
    localparam int          TWSC_AUTO_BIT   = 5;        // auto transfer sel
    localparam int          TWSC_CLKHI_BIT  = 1;        // 0 = external clk
    localparam int          TWSC_CLKLO_BIT  = 0;        // 1 = prescaler
    localparam logic [7:0]  TWSC_MODE_WMASK = 8'hE3;    // bits 4..2 read 0
    localparam logic [7:0]  TWSC_MODE_RST   = 8'h00;    // after reset
    localparam logic [7:0]  TWSC_SHIFT_RST  = 8'h00;    // after reset

    ////////////////////////////////////////////////////////////////////////
    // transfer shape
    localparam int          TWSC_BITS       = 8;        // bits per unit
    localparam logic [2:0]  TWSC_LAST_BIT   = 3'h7;     // index of eighth

    ////////////////////////////////////////////////////////////////////////
    // cpu request carrier
    typedef struct packed {
        logic [15:0] addr;     // byte address
        logic        wr;       // whole-byte write strobe
        logic        bit_wr;   // single-bit write strobe
        logic [2:0]  bit_sel;  // bit position for bit_wr
        logic        bit_val;  // bit value for bit_wr
        logic        rd;       // read strobe
        logic [7:0]  wdata;    // byte to write
    } twsc_cpu_req_t;

    // pin ownership carrier
    typedef struct packed {
        logic        so_oe;    // serial out driven
        logic        sck_oe;   // serial clock driven
        logic        si_used;  // serial in sampled
        logic        released; // all channel pins free for port use
    } twsc_pin_own_t;

    // engine states, one-hot
    typedef enum logic [2:0] {
        TWSC_IDLE    = 3'b001, // no transfer
        TWSC_INT_RUN = 3'b010, // internal clock transfer
        TWSC_EXT_RUN = 3'b100  // external clock transfer
    } twsc_state_t;

endpackage : twsc_pkg

// *** logic/twsc_link_shifter.sv ***
// twsc_link_shifter: shifter clocked by the external serial clock pin.
// assumes the cpu side holds arm_tog and tx_word stable while armed and
// that the serial clock idles high between units.
`timescale 1ns/1ps
`default_nettype none
module twsc_link_shifter (
    input  wire logic       link_clk,  // external serial clock
    input  wire logic       rst,       // channel reset, active high
    input  wire logic       arm_tog,   // toggles once per armed unit
    input  wire logic [7:0] tx_word,   // unit to send, msb goes first
    input  wire logic       rx_en,     // capture serial input
    input  wire logic       si,        // serial input pin
    output logic            so_ext,    // serial output level
    output logic            ack_tog,   // follows arm_tog after 8 bits
    output logic [7:0]      rx_word    // received unit
);
    import twsc_pkg::*;

    logic [2:0] pos_cnt_reg;  // rising edges seen in this unit
    logic       so_reg;       // output latch
    logic       seen_tog_reg; // arm_tog copy taken at first falling edge
    logic       active;       // a unit is armed and not finished

    // armed inputs are quasi-static: written before the clock moves
    assign active = (arm_tog != ack_tog);

    ////////////////////////////////////////////////////////////////////////
    // falling edge: present next transmit bit on the latch
    // an async clear is used because this clock may stand still
    always_ff @(negedge link_clk or posedge rst) begin
        if (rst) begin
            so_reg       <= 1'b0;
            seen_tog_reg <= 1'b0;
        end else if (active) begin
            so_reg       <= tx_word[3'h7 - pos_cnt_reg];
            seen_tog_reg <= arm_tog;
        end
    end

    // latch is forced low from the write until the first falling edge
    assign so_ext = (seen_tog_reg == arm_tog) ? so_reg : 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // rising edge: capture input and count bits
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            pos_cnt_reg <= 3'h0;
            ack_tog     <= 1'b0;
            rx_word     <= TWSC_SHIFT_RST;
        end else if (active) begin
            rx_word     <= {rx_word[6:0], rx_en & si};
            pos_cnt_reg <= pos_cnt_reg + 3'h1;
            if (pos_cnt_reg == TWSC_LAST_BIT) begin
                ack_tog <= arm_tog;
            end
        end
    end

endmodule : twsc_link_shifter
`default_nettype wire

// *** verif/twsc_peer.sv ***
// twsc_peer: peripheral on the far side of the three serial lines.
// assumes the bench resolves the clock pin and feeds it back as sck.
`timescale 1ns/1ps
`default_nettype none
module twsc_peer (
    input  wire logic sck,      // resolved clock pin
    input  wire logic so,       // device serial out
    output logic      peer_sck, // clock made when master
    output logic      si        // device serial in
);
    logic [7:0] tx_sh = 8'h00; // bits still to send
    logic [7:0] rx_sh = 8'h00; // bits taken from so
    initial begin
        peer_sck = 1'b1;
        si = 1'b0;
    end
    // new unit: fresh transmit word, empty receive word
    task load(input logic [7:0] b);
        tx_sh = b;
        rx_sh = 8'h00;
    endtask
    // master: eight low-high cycles of 30 ns, idle high
    task clock_unit;
        #7;
        repeat (8) begin
            #15 peer_sck = 1'b0;
            #15 peer_sck = 1'b1;
        end
    endtask
    // next bit out on the falling edge
    always @(negedge sck) si = tx_sh[7];
    // capture on the rising edge, then spoil the held bit
    always @(posedge sck) begin
        rx_sh = {rx_sh[6:0], so};
        tx_sh = {tx_sh[6:0], 1'b0};
        #5 si = ~si;
    end
endmodule // twsc_peer
`default_nettype wire

// *** verif/twsc_channel_test.sv ***
// twsc_channel_test: register and transfer tests of the channel.
// assumes twsc_peer on the serial lines.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin n_fail++; \
$display("mismatch %s exp %h got %h", n, e, g); end end
module twsc_channel_test;
    import twsc_pkg::*;
    logic          ref_clk = 0, rst = 1, tm2_tick = 0, timer_clock_select_three_tick = 0;
    logic          rx_en   = 1;  // receive enable level
    logic [1:0]    tick_on = 0;  // running tick sources
    logic [1:0]    cnt     = 0;  // tick spacing
    twsc_cpu_req_t req     = '0; // cpu request
    twsc_pin_own_t own;
    logic [7:0]    rdata;
    logic          sck_out, sck_oe, so, so_oe, done, si, peer_sck;
    wire logic     sck = sck_oe ? sck_out : peer_sck; // clock pin
    int            n_fail = 0, checked = 0, nfall = 0;
    always #2 ref_clk = ~ref_clk;
    always @(negedge sck) nfall++;
    // a tick every fourth cycle, one half serial clock each
    always @(posedge ref_clk) begin
        cnt <= cnt + 2'h1;
        tm2_tick <= tick_on[0] && cnt == 2'h0;
        timer_clock_select_three_tick <= tick_on[1] && cnt == 2'h0;
    end
    twsc_channel dut_u (.ref_clk, .rst, .cpu_req(req), .cpu_rdata(rdata),
        .tm2_tick, .timer_clock_select_three_tick, .receive_enable_bit(rx_en),
        .sck_pin_in(sck), .sck_pin_out(sck_out), .sck_pin_oe(sck_oe),
        .si_pin_in(si), .so_pin_out(so), .so_pin_oe(so_oe),
        .pin_own(own), .transfer_done_flag(done));
    twsc_peer peer_u (.sck, .so, .peer_sck, .si);
    // one cpu access, held across one sampling edge
    task cyc(input logic w, b, r, input logic [15:0] a,
             input logic [7:0] v, input logic [2:0] s);
        @(posedge ref_clk);
        #1 req = '{a, w, b, s, v[0], r, v};
        @(posedge ref_clk);
        #1 req = '0;
    endtask
    task wr(input logic [15:0] a, input logic [7:0] v);
        cyc(1, 0, 0, a, v, 3'h0);
    endtask
    task rd(input logic [15:0] a);
        cyc(0, 0, 1, a, 8'h00, 3'h0);
    endtask
    // bounded wait for the done pulse
    task wait_done;
        for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge ref_clk) #1;
        `CHK("done", 1'b1, done)
    endtask
    task conclude;
        $display("n_fail %0d checked %0d", n_fail, checked);
        if (n_fail == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100000 n_fail++;
        conclude;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rst = 0;
        rd(TWSC_MODE_ADDR); `CHK("mode", 8'h00, rdata)
        wr(TWSC_MODE_ADDR, 8'hFF); rd(TWSC_MODE_ADDR);
        `CHK("mode", 8'hE3, rdata)
        tick_on = 2; nfall = 0; wr(TWSC_SHIFT_ADDR, 8'h00);
        repeat (20) @(posedge ref_clk); tick_on = 0;
        `CHK("auto", 0, nfall)
        wr(TWSC_MODE_ADDR, 8'h00); wr(TWSC_SHIFT_ADDR, 8'h5A);
        rd(TWSC_SHIFT_ADDR); `CHK("shift", 8'h5A, rdata)
        `CHK("released", 1'b1, own.released)
        `CHK("oe", 2'b00, {sck_oe, so_oe})
        cyc(0, 1, 0, TWSC_MODE_ADDR, 8'h01, 3'h1);
        cyc(0, 1, 0, TWSC_MODE_ADDR, 8'h01, 3'h7);
        rd(TWSC_MODE_ADDR); `CHK("bits", 8'h82, rdata)
        nfall = 0; tick_on = 1; repeat (80) @(posedge ref_clk);
        `CHK("late", 0, nfall)
        `CHK("oe", 2'b11, {sck_oe, so_oe})
        tick_on = 0; peer_u.load(8'h3C); wr(TWSC_SHIFT_ADDR, 8'hA5);
        @(posedge ref_clk) #1; `CHK("so", 1'b0, so)
        nfall = 0; tick_on = 1; wait_done;
        `CHK("falls", 8, nfall)
        `CHK("peer", 8'hA5, peer_u.rx_sh)
        rd(TWSC_SHIFT_ADDR); `CHK("rx", 8'h3C, rdata)
        wr(TWSC_MODE_ADDR, 8'hC3); tick_on = 2; peer_u.load(8'h03);
        wr(TWSC_SHIFT_ADDR, 8'h01); wait_done;
        `CHK("lsb", 8'h80, peer_u.rx_sh)
        rd(TWSC_SHIFT_ADDR); `CHK("lsb rx", 8'hC0, rdata)
        tick_on = 0; wr(TWSC_MODE_ADDR, 8'h80); peer_u.load(8'h5C);
        wr(TWSC_SHIFT_ADDR, 8'h96); repeat (3) @(posedge ref_clk);
        `CHK("ext oe", 1'b0, sck_oe)
        peer_u.clock_unit; wait_done;
        `CHK("ext", 8'h96, peer_u.rx_sh)
        rd(TWSC_SHIFT_ADDR); `CHK("ext rx", 8'h5C, rdata)
        rx_en = 0; repeat (2) @(posedge ref_clk);
        `CHK("si", 1'b0, own.si_used)
        wr(TWSC_MODE_ADDR, 8'h00);
        `CHK("free", 3'b100, {own.released, sck_oe, so_oe})
        conclude;
    end
endmodule // twsc_channel_test
`default_nettype wire
